// ### rtl/message_queue_port_unit.sv
// Message queue port unit: four circular queues of frame addresses in local memory,
// reached by the PCI side through two queue ports in the first memory window.
// Assumes target core, local memory and config bits run on mclk; the core holds
// pciReq until it sees pciAck or pciRetry.
//
// Behaviour
// [RULE1] Local processor adds inbound free frames, advances head.
// [RULE2] Empty inbound free read returns all ones.
// [RULE3] Inbound read returns tail entry, advances tail.
// [RULE4] Prefetch enabled inbound free entry into holding register.
// [RULE5] Inbound port write stores at post head, advances.
// [RULE6] Local processor owns and advances inbound post tail.
// [RULE7] Inbound post not empty raises masked local interrupt.
// [RULE8] Retry all accesses until inbound post write done.
// [RULE9] Local master posts outbound frames, advances head.
// [RULE10] Outbound read returns all ones or post tail.
// [RULE11] Outbound post pointers differ raises masked PCI interrupt.
// [RULE12] Prefetch tail after tail advance or head from empty.
// [RULE13] Outbound port write stores at free head, advances.
// [RULE14] Local processor checks outbound free before taking.
// [RULE15] Outbound free full raises overflow interrupt and status.
// [RULE16] Retry all accesses until outbound free write done.
// [RULE17] Local processor performs the enable sequence.
// [RULE18] Retry every access until init done is set.
// [RULE19] Offsets up to FFh reach configuration registers.
// [RULE20] Offsets above FFh reach space one past base.
// [RULE21] Inbound free frames must lie above FFh.
// [RULE22] Device wraps its pointers and adds queue base.
// [RULE23] Empty when disabled or head equals tail.
// [RULE24] Full only when enabled and head advance meets tail.
// [RULE25] Four equal queues contiguous in fixed order.
// [RULE26] One pointer update per single word access.
`timescale 1ns/1ps
`default_nettype none

module message_queue_port_unit (
	input  wire logic                 mclk,
	input  wire logic                 arst_n,
	input  wire logic                 pciReq,
	input  wire logic                 pciWrite,
	input  wire logic [31:0]          pciOffset,
	input  wire logic [31:0]          pciWrData,
	output logic                      pciAck,
	output logic                      pciRetry,
	output logic [31:0]               pciRdData,
	output logic                      cfgHit,
	output logic                      space1Hit,
	output logic [31:0]               space1Addr,
	input  wire logic [31:0]          space1LocalBase,
	input  wire logic                 queueEnable,
	input  wire logic                 decodeEnable,
	input  wire logic                 initDone,
	input  wire logic                 inFreePrefetchEn,
	input  wire logic                 inPostIrqMask,
	input  wire logic                 outPostIrqMask,
	input  wire logic                 errorPinMode,
	input  wire logic [`MQ_BASE_W-1:0] queueBase,
	input  wire logic [4:0]           queueSizeCode,
	input  wire logic                 ptrWrEn,
	input  wire logic                 ptrWrTail,
	input  wire mq_pkg::qid_t         ptrWrQ,
	input  wire mq_pkg::ptr_t         ptrWrData,
	input  wire logic                 ptrRdTail,
	input  wire mq_pkg::qid_t         ptrRdQ,
	output mq_pkg::ptr_t              ptrRdData,
	input  wire logic                 ovfClear,
	output logic [3:0]                emptyFlags,
	output logic [3:0]                fullFlags,
	output logic                      inPostNotEmpty,
	output logic                      outPostIrqStatus,
	output logic                      outFreeOverflow,
	output logic                      local_irq_out_n,
	output logic                      local_error_irq_n,
	output logic                      pciIrq_n,
	output logic                      memValid,
	input  wire logic                 memReady,
	output logic                      memWrite,
	output logic [31:0]               memAddr,
	output logic [31:0]               memWrData,
	input  wire logic                 memDone,
	input  wire logic [31:0]          memRdData
);
	import mq_pkg::*;

	// ****************************************************************
	// Helper functions
	// ****************************************************************
	// Queue size in bytes; codes above the largest size clamp to it.
	function automatic ptr_t sizeBytes(input logic [4:0] code);
		logic [4:0] c;
		c = (code > `MQ_MAX_CODE) ? `MQ_MAX_CODE : code;
		return ptr_t'(`MQ_MIN_BYTES << c);
	endfunction

	// Next pointer value, wrapping to zero at the queue size.
	function automatic ptr_t nextPtr(input ptr_t p, input logic [4:0] code);
		ptr_t n;
		n = p + `MQ_ENTRY_BYTES;
		return (n >= sizeBytes(code)) ? '0 : n; // see [RULE22]
	endfunction

	// Local address of an entry: base plus queue index times size plus offset.
	function automatic logic [31:0] entryAddr(input logic [`MQ_BASE_W-1:0] base,
	                                          input logic [4:0] code,
	                                          input qid_t q,
	                                          input ptr_t p);
		logic [31:0] qOff;
		qOff = 32'(sizeBytes(code)) * 32'(q); // see [RULE25]
		return {base, `MQ_BASE_LSB'(0)} + qOff + 32'(p); // see [RULE22]
	endfunction

	mq_state_t stateFf;
	mq_state_t nxtState;
	mq_buf_if  reqIn ();
	mq_buf_if  reqOut ();
	logic [3:0] empty;
	logic      isInPort;
	logic      isOutPort;
	logic      isPort;
	logic      newReq;
	logic      pfInWant;
	logic      pfOutWant;

	// ****************************************************************
	// Decode of the shared window
	// ****************************************************************
	// Empty is forced while the queues are disabled.
	always_comb begin
		for (int i = 0; i < 4; i++) begin
			empty[i] = !queueEnable || (stateFf.head[i] == stateFf.tail[i]); // see [RULE23]
		end
	end

	assign isInPort  = (pciOffset == `MQ_INQ_PORT);
	assign isOutPort = (pciOffset == `MQ_OUTQ_PORT);
	assign isPort    = decodeEnable && (isInPort || isOutPort);
	// A request still high in the cycle its answer shows is the old one.
	assign newReq    = pciReq && !stateFf.ack && !stateFf.retry;

	// Accesses pass to config or space 1 only when nothing forces a retry.
	assign cfgHit     = newReq && decodeEnable && initDone && (stateFf.st != ST_WR_WAIT) &&
	                    !isPort && (pciOffset <= `MQ_CFG_LAST); // see [RULE19]
	assign space1Hit  = newReq && decodeEnable && initDone && (stateFf.st != ST_WR_WAIT) &&
	                    (pciOffset > `MQ_CFG_LAST); // see [RULE20]
	// The low 100h of space 1 are shadowed by the config block.
	assign space1Addr = space1LocalBase + pciOffset; // see [RULE20]

	// Prefetch wanted: tail entry not held yet and the queue holds something.
	assign pfInWant  = inFreePrefetchEn && !empty[QIN_FREE] && !stateFf.pfValid[0]; // see [RULE4]
	assign pfOutWant = !empty[QOUT_POST] && !stateFf.pfValid[1]; // see [RULE12]

	// ****************************************************************
	// Request buffer towards local memory
	// ****************************************************************
	// One request open at a time; a stalled memory holds it in the buffer.
	assign reqIn.valid = stateFf.reqValid;
	assign reqIn.data  = stateFf.req;

	mq_req_buffer #(
		.DEPTH (`MQ_BUF_DEPTH)
	) u_req_buffer (
		.mclk  (mclk),
		.arst_n(arst_n),
		.fill  (reqIn.snk),
		.drain (reqOut.src)
	);

	assign memValid     = reqOut.valid;
	assign memWrite     = reqOut.data.write;
	assign memAddr      = reqOut.data.addr;
	assign memWrData    = reqOut.data.data;
	assign reqOut.ready = memReady;

	// ****************************************************************
	// Main sequencer
	// ****************************************************************
	// One process forms the whole next state.
	always_comb begin
		nxtState       = stateFf;
		nxtState.ack   = 1'b0;
		nxtState.retry = 1'b0;
		if (stateFf.reqValid && reqIn.ready) begin
			nxtState.reqValid = 1'b0;
		end

		unique case (stateFf.st)
			ST_IDLE: begin
				if (newReq && !initDone) begin
					nxtState.retry = 1'b1; // see [RULE18]
				end else if (newReq && isPort && pciWrite) begin
					// Posted write: answered now, stored afterwards under retry cover.
					nxtState.ack      = 1'b1;
					nxtState.busyQ    = isInPort ? QIN_POST : QOUT_FREE; // see [RULE5] [RULE13]
					nxtState.reqValid = 1'b1;
					nxtState.req      = '{write: 1'b1,
					                      addr: entryAddr(queueBase, queueSizeCode,
					                                      nxtState.busyQ,
					                                      stateFf.head[nxtState.busyQ]),
					                      data: pciWrData};
					nxtState.st       = ST_WR_WAIT;
				end else if (newReq && isPort) begin
					nxtState.busyQ = isInPort ? QIN_FREE : QOUT_POST;
					if (empty[nxtState.busyQ]) begin
						nxtState.ack    = 1'b1;
						nxtState.rdData = `MQ_EMPTY_WORD; // see [RULE2] [RULE10]
					end else if (stateFf.pfValid[isOutPort]) begin
						// Held entry answers at once; no wait on local memory.
						nxtState.ack                = 1'b1;
						nxtState.rdData             = stateFf.pfData[isOutPort]; // see [RULE4]
						nxtState.pfValid[isOutPort] = 1'b0;
						nxtState.tail[nxtState.busyQ] =
							nextPtr(stateFf.tail[nxtState.busyQ], queueSizeCode); // see [RULE26]
					end else begin
						nxtState.reqValid = 1'b1;
						nxtState.req      = '{write: 1'b0,
						                      addr: entryAddr(queueBase, queueSizeCode,
						                                      nxtState.busyQ,
						                                      stateFf.tail[nxtState.busyQ]),
						                      data: 32'h0000_0000}; // see [RULE3] [RULE10]
						nxtState.st       = ST_RD_WAIT;
					end
				end else if (!newReq && (pfInWant || pfOutWant)) begin
					// Prefetch starts only in idle bus cycles; a host access arriving during it waits until ST_PF_WAIT ends.
					nxtState.busyQ    = pfOutWant ? QOUT_POST : QIN_FREE;
					nxtState.reqValid = 1'b1;
					nxtState.req      = '{write: 1'b0,
					                      addr: entryAddr(queueBase, queueSizeCode,
					                                      nxtState.busyQ,
					                                      stateFf.tail[nxtState.busyQ]),
					                      data: 32'h0000_0000}; // see [RULE12]
					nxtState.st       = ST_PF_WAIT;
				end
			end
			ST_WR_WAIT: begin
				if (newReq) begin
					nxtState.retry = 1'b1; // see [RULE8] [RULE16]
				end
				if (memDone) begin
					nxtState.head[stateFf.busyQ] =
						nextPtr(stateFf.head[stateFf.busyQ], queueSizeCode); // see [RULE5] [RULE13]
					if (queueEnable &&
					    nxtState.head[stateFf.busyQ] == stateFf.tail[stateFf.busyQ]) begin
						nxtState.full[stateFf.busyQ] = 1'b1; // see [RULE24]
						if (stateFf.busyQ == QOUT_FREE) begin
							nxtState.ovf = 1'b1; // see [RULE15]
						end
					end
					nxtState.st = ST_IDLE;
				end
			end
			ST_RD_WAIT: begin
				if (memDone) begin
					nxtState.ack    = 1'b1;
					nxtState.rdData = memRdData; // see [RULE3] [RULE10]
					nxtState.tail[stateFf.busyQ] =
						nextPtr(stateFf.tail[stateFf.busyQ], queueSizeCode); // see [RULE26]
					nxtState.st     = ST_IDLE;
				end
			end
			ST_PF_WAIT: begin
				if (memDone) begin
					nxtState.pfData[stateFf.busyQ == QOUT_POST]  = memRdData; // see [RULE4]
					nxtState.pfValid[stateFf.busyQ == QOUT_POST] = 1'b1;
					nxtState.st = ST_IDLE;
				end
			end
		endcase

		// Local processor pointer writes; a tail rewrite drops the held entry.
		if (ptrWrEn) begin
			if (ptrWrTail) begin
				nxtState.tail[ptrWrQ] = ptrWrData; // see [RULE6] [RULE14]
				if (ptrWrQ == QIN_FREE) nxtState.pfValid[0] = 1'b0;
				if (ptrWrQ == QOUT_POST) nxtState.pfValid[1] = 1'b0;
			end else begin
				nxtState.head[ptrWrQ] = ptrWrData; // see [RULE1] [RULE9]
				if (queueEnable && ptrWrData == stateFf.tail[ptrWrQ] &&
				    ptrWrData != stateFf.head[ptrWrQ]) begin
					nxtState.full[ptrWrQ] = 1'b1; // see [RULE24]
				end
			end
		end

		// Full clears once disabled or the pointers part again.
		for (int i = 0; i < 4; i++) begin
			if (!queueEnable || nxtState.head[i] != nxtState.tail[i]) begin
				nxtState.full[i] = 1'b0; // see [RULE24]
			end
		end
		if (!queueEnable) begin
			nxtState.pfValid = '0;
		end

		// A new overflow in the clearing cycle survives the clear unless the flag was already set.
		if (ovfClear && !(nxtState.ovf && !stateFf.ovf)) begin
			nxtState.ovf = 1'b0; // see [RULE15]
		end
		nxtState.ptrRd = ptrRdTail ? stateFf.tail[ptrRdQ] : stateFf.head[ptrRdQ];
	end

	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			stateFf <= '0;
		end else begin
			stateFf <= nxtState;
		end
	end

	// ****************************************************************
	// Status and interrupt outputs
	// ****************************************************************
	assign pciAck           = stateFf.ack;
	assign pciRetry         = stateFf.retry;
	assign pciRdData        = stateFf.rdData;
	assign ptrRdData        = stateFf.ptrRd;
	assign emptyFlags       = empty;
	assign fullFlags        = stateFf.full;
	assign inPostNotEmpty   = !empty[QIN_POST]; // see [RULE7]
	assign outPostIrqStatus = !empty[QOUT_POST]; // see [RULE11]
	assign outFreeOverflow  = stateFf.ovf;

	// Overflow goes to the pin chosen by the bus mode.
	assign local_irq_out_n   = !((inPostNotEmpty && !inPostIrqMask) ||
	                             (stateFf.ovf && !errorPinMode)); // see [RULE7] [RULE15]
	assign local_error_irq_n = !(stateFf.ovf && errorPinMode); // see [RULE15]
	assign pciIrq_n          = !(outPostIrqStatus && !outPostIrqMask); // see [RULE11]
endmodule

`default_nettype wire

// ### include/mq_defs.svh
// Offsets, geometry and buffer depth of the message queue unit.
// Included by the package only; expects nothing else to have been defined.
`ifndef MQ_DEFS_SVH
`define MQ_DEFS_SVH

// ****************************************************************
// Queue port offsets inside the first memory window
// ****************************************************************
`define MQ_INQ_PORT      32'h0000_0040
`define MQ_OUTQ_PORT     32'h0000_0044
`define MQ_CFG_LAST      32'h0000_00FF
`define MQ_EMPTY_WORD    32'hFFFF_FFFF

// ****************************************************************
// Circular queue geometry
// ****************************************************************
`define MQ_PTR_W         19
`define MQ_ENTRY_BYTES   19'h0_0004
`define MQ_MIN_BYTES     19'h0_4000
`define MQ_MAX_CODE      5'h04
`define MQ_BASE_W        12
`define MQ_BASE_LSB      20
`define MQ_BUF_DEPTH     2

`endif

// ### include/mq_pkg.sv
// Types shared by the message queue unit and its request buffer.
// Assumes mq_defs.svh is on the include path.
`include "mq_defs.svh"

package mq_pkg;

	// Queue order matches the layout in local memory.
	typedef enum logic [1:0] {
		QIN_FREE,
		QIN_POST,
		QOUT_POST,
		QOUT_FREE
	} qid_t;

	typedef enum logic [1:0] {
		ST_IDLE,
		ST_WR_WAIT,
		ST_RD_WAIT,
		ST_PF_WAIT
	} state_t;

	typedef logic [`MQ_PTR_W-1:0] ptr_t;

	// One memory request: write flag, address and write data.
	typedef struct packed {
		logic        write;
		logic [31:0] addr;
		logic [31:0] data;
	} memreq_t;

	typedef struct packed {
		state_t         st;
		qid_t           busyQ;
		logic [3:0][`MQ_PTR_W-1:0] head;
		logic [3:0][`MQ_PTR_W-1:0] tail;
		logic [3:0]     full;
		logic [1:0]     pfValid;
		logic [1:0][31:0] pfData;
		logic           ovf;
		logic           ack;
		logic           retry;
		logic [31:0]    rdData;
		logic           reqValid;
		memreq_t        req;
		logic [`MQ_PTR_W-1:0] ptrRd;
	} mq_state_t;

endpackage

// ### include/mq_buf_if.sv
// Valid/ready carrier for memory requests between the unit and its buffer.
// Single clock domain; no clocking block.
`timescale 1ns/1ps
`default_nettype none

interface mq_buf_if;
	logic               valid;
	logic               ready;
	mq_pkg::memreq_t    data;

	modport src (output valid, output data, input ready);
	modport snk (input valid, input data, output ready);
endinterface

`default_nettype wire

// ### rtl/mq_req_buffer.sv
// Two-entry request buffer with valid and ready on both sides.
// Assumes one clock; the drain side may stall at will.
`timescale 1ns/1ps
`default_nettype none

module mq_req_buffer
	import mq_pkg::*;
#(
	parameter int DEPTH = `MQ_BUF_DEPTH
) (
	input  wire logic mclk,
	input  wire logic arst_n,
	mq_buf_if.snk     fill,
	mq_buf_if.src     drain
);
	import mq_pkg::*;

	typedef struct packed {
		logic [DEPTH-1:0][$bits(memreq_t)-1:0] mem;
		logic [$clog2(DEPTH)-1:0]              wrIdx;
		logic [$clog2(DEPTH)-1:0]              rdIdx;
		logic [$clog2(DEPTH):0]                count;
	} buf_state_t;

	buf_state_t stateFf;
	buf_state_t nxtState;
	logic       push;
	logic       pop;

	// ****************************************************************
	// Handshakes
	// ****************************************************************
	// Full and empty come straight from the count.
	assign fill.ready  = (stateFf.count != ($clog2(DEPTH)+1)'(DEPTH));
	assign drain.valid = (stateFf.count != '0);
	assign drain.data  = memreq_t'(stateFf.mem[stateFf.rdIdx]);
	assign push        = fill.valid && fill.ready;
	assign pop         = drain.valid && drain.ready;

	// Next state: index-addressed storage with wrapping pointers.
	always_comb begin
		nxtState = stateFf;
		if (push) begin
			nxtState.mem[stateFf.wrIdx] = fill.data;
			nxtState.wrIdx = (stateFf.wrIdx == ($clog2(DEPTH))'(DEPTH-1)) ? '0 : stateFf.wrIdx + 1'b1;
		end
		if (pop) begin
			nxtState.rdIdx = (stateFf.rdIdx == ($clog2(DEPTH))'(DEPTH-1)) ? '0 : stateFf.rdIdx + 1'b1;
		end
		if (push && !pop) begin
			nxtState.count = stateFf.count + 1'b1;
		end else if (pop && !push) begin
			nxtState.count = stateFf.count - 1'b1;
		end
	end

	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			stateFf <= '0;
		end else begin
			stateFf <= nxtState;
		end
	end
endmodule

`default_nettype wire

// ### verif/mq_mem_model.sv
// Behavioural local memory that answers the unit's request stream.
// Assumes one outstanding request.
`timescale 1ns/1ps
`default_nettype none

module mq_mem_model (
	input  wire logic        mclk,
	input  wire logic        arst_n,
	input  wire logic        memValid,
	input  wire logic        memWrite,
	input  wire logic [31:0] memAddr,
	input  wire logic [31:0] memWrData,
	input  wire logic        memSlow,
	output logic             memReady,
	output logic             memDone,
	output logic [31:0]      memRdData
);
	// ********************
	// Storage and timing
	// ********************
	logic [31:0] mem [logic [31:0]];
	logic [31:0] aHeld;
	logic [31:0] dHeld;
	logic        wHeld;
	logic [2:0]  cnt;

	// Ready only while idle, so a slow answer stalls the buffer.
	assign memReady = (cnt == 3'h0);

	// The queues are plain words here; the unit forms every address.
	// Read data flips each cycle so a stale word never passes.
	always @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			cnt <= 3'h0;
			memDone <= 1'b0;
			memRdData <= 32'h0;
		end else begin
			memDone <= 1'b0;
			memRdData <= ~memRdData;
			if (cnt == 3'h0 && memValid) begin
				aHeld <= memAddr;
				dHeld <= memWrData;
				wHeld <= memWrite;
				cnt <= memSlow ? 3'h5 : 3'h1;
			end else if (cnt != 3'h0) begin
				cnt <= cnt - 3'h1;
				if (cnt == 3'h1) begin
					memDone <= 1'b1;
					if (wHeld) mem[aHeld] = dHeld;
					else if (mem.exists(aHeld)) memRdData <= mem[aHeld];
				end
			end
		end
	end
endmodule

`default_nettype wire

// ### verif/message_queue_port_unit_chk.sv
// Concurrent checks on the message queue unit's ports.
// Assumes errorPinMode high and one request at a time.
`timescale 1ns/1ps
`default_nettype none

module message_queue_port_unit_chk (
	input  wire logic        mclk,
	input  wire logic        arst_n,
	input  wire logic        pciReq,
	input  wire logic        pciWrite,
	input  wire logic [31:0] pciOffset,
	input  wire logic        pciAck,
	input  wire logic        pciRetry,
	input  wire logic [31:0] pciRdData,
	input  wire logic        cfgHit,
	input  wire logic        space1Hit,
	input  wire logic [31:0] space1Addr,
	input  wire logic [31:0] space1LocalBase,
	input  wire logic        queueEnable,
	input  wire logic        initDone,
	input  wire logic        inPostIrqMask,
	input  wire logic        outPostIrqMask,
	input  wire logic        errorPinMode,
	input  wire logic [3:0]  emptyFlags,
	input  wire logic [3:0]  fullFlags,
	input  wire logic        inPostNotEmpty,
	input  wire logic        outPostIrqStatus,
	input  wire logic        outFreeOverflow,
	input  wire logic        local_irq_out_n,
	input  wire logic        local_error_irq_n,
	input  wire logic        pciIrq_n,
	input  wire logic        memValid,
	input  wire logic        memReady,
	input  wire logic [31:0] memAddr
);
	// ********************
	// Properties
	// ********************
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!arst_n);

	// A new request before init is retried next cycle.
	property p_no_init;
		pciReq && !initDone && !pciAck && !pciRetry |=> pciRetry && !pciAck;
	endproperty
	a_no_init: assert property (p_no_init) else $error("access served before init");

	property p_empty_read;
		pciReq && !pciWrite && pciOffset == 32'h40 && emptyFlags[0] && !pciAck && !pciRetry
		|-> ##[1:40] (pciRetry || (pciAck && pciRdData == 32'hFFFFFFFF));
	endproperty
	a_empty_read: assert property (p_empty_read) else $error("empty read not all ones");

	property p_ack_pulse;
		pciAck |=> !pciAck && !pciRetry;
	endproperty
	a_ack_pulse: assert property (p_ack_pulse) else $error("ack longer than one cycle");

	property p_in_irq;
		errorPinMode |-> local_irq_out_n == !(inPostNotEmpty && !inPostIrqMask);
	endproperty
	a_in_irq: assert property (p_in_irq) else $error("local interrupt wrong");

	property p_pci_irq;
		pciIrq_n == !(outPostIrqStatus && !outPostIrqMask);
	endproperty
	a_pci_irq: assert property (p_pci_irq) else $error("host interrupt wrong");

	property p_out_status;
		queueEnable |-> outPostIrqStatus == !emptyFlags[2];
	endproperty
	a_out_status: assert property (p_out_status) else $error("status and empty differ");

	property p_ovf_pin;
		errorPinMode |-> local_error_irq_n == !outFreeOverflow;
	endproperty
	a_ovf_pin: assert property (p_ovf_pin) else $error("overflow pin wrong");

	property p_disabled;
		!queueEnable |-> emptyFlags == 4'hF ##1 fullFlags == 4'h0;
	endproperty
	a_disabled: assert property (p_disabled) else $error("flags wrong while off");

	property p_cfg_range;
		cfgHit |-> pciOffset <= 32'hFF && !space1Hit;
	endproperty
	a_cfg_range: assert property (p_cfg_range) else $error("config hit out of range");

	property p_space1;
		space1Hit |-> pciOffset > 32'hFF && space1Addr == space1LocalBase + pciOffset;
	endproperty
	a_space1: assert property (p_space1) else $error("space one remap wrong");

	// A stalled request must hold.
	property p_mem_hold;
		memValid && !memReady |=> memValid && $stable(memAddr);
	endproperty
	a_mem_hold: assert property (p_mem_hold) else $error("request changed in stall");
endmodule

bind message_queue_port_unit message_queue_port_unit_chk u_chk (.*);

`default_nettype wire

// ### verif/message_queue_port_unit_tb.sv
// Self-checking bench for the message queue unit with a memory model behind it.
// Assumes the memory model in mq_mem_model.sv.
`timescale 1ns/1ps
`default_nettype none

module message_queue_port_unit_tb;
	import mq_pkg::*;
	`define CHK(a, b) begin checked++; if ((a) !== (b)) begin errors++; \
		$display("BAD %0t got %h exp %h", $time, (a), (b)); end end

	// ********************
	// Signals
	// ********************
	logic mclk = 1'b0, arst_n = 1'b0, pciReq = 1'b0, pciWrite = 1'b0;
	logic [31:0] pciOffset = 32'h0, pciWrData = 32'h0, space1LocalBase = 32'h0800_0000;
	logic queueEnable = 1'b0, decodeEnable = 1'b0, initDone = 1'b0, memSlow = 1'b0;
	logic inFreePrefetchEn = 1'b0, inPostIrqMask = 1'b0, outPostIrqMask = 1'b0;
	logic errorPinMode = 1'b1, ptrWrEn = 1'b0, ptrWrTail = 1'b0, ptrRdTail = 1'b0;
	logic ovfClear = 1'b0;
	logic [11:0] queueBase = 12'h001;
	logic [4:0] queueSizeCode = 5'h00;
	qid_t ptrWrQ = QIN_FREE, ptrRdQ = QIN_FREE;
	ptr_t ptrWrData = '0, ptrRdData;
	logic pciAck, pciRetry, cfgHit, space1Hit, inPostNotEmpty, outPostIrqStatus;
	logic outFreeOverflow, local_irq_out_n, local_error_irq_n, pciIrq_n;
	logic memValid, memReady, memWrite, memDone;
	logic [31:0] pciRdData, space1Addr, memAddr, memWrData, memRdData;
	logic [3:0] emptyFlags, fullFlags;
	int errors = 0, checked = 0, cycles = 0, l;
	logic a, t;
	logic [31:0] r;

	message_queue_port_unit u_dut (.*);
	mq_mem_model u_mem (.*);

	// Half period of 2 ns gives the 250 MHz clock.
	always #2 mclk = ~mclk;

	// The run needs under 1000 cycles; this ceiling only cuts a hang.
	always @(posedge mclk) begin
		cycles++;
		if (cycles == 4000) begin
			errors++;
			end_of_test();
		end
	end

	// ********************
	// Tasks
	// ********************
	function automatic logic [31:0] qa(input int q, input int p);
		return 32'h0010_0000 + q * 32'h4000 + p;
	endfunction

	task automatic end_of_test();
		if (errors == 0 && checked > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask

	task automatic cyc(input int n);
		repeat (n) @(posedge mclk);
		#1;
	endtask

	// One access, held until answered; l is 1 when served at once.
	task automatic pci(input logic w, input logic [31:0] off, input logic [31:0] d);
		@(posedge mclk);
		#1;
		pciReq = 1'b1;
		pciWrite = w;
		pciOffset = off;
		pciWrData = d;
		l = 0;
		do begin
			cyc(1);
			l++;
		end while (!(pciAck === 1'b1 || pciRetry === 1'b1) && l < 60);
		a = pciAck;
		t = pciRetry;
		r = pciRdData;
		pciReq = 1'b0;
	endtask

	task automatic ptrw(input qid_t q, input logic tl, input ptr_t v);
		cyc(1);
		{ptrWrEn, ptrWrTail, ptrWrQ, ptrWrData} = {1'b1, tl, q, v};
		cyc(1);
		ptrWrEn = 1'b0;
	endtask

	task automatic ptrchk(input qid_t q, input logic tl, input ptr_t v);
		{ptrRdQ, ptrRdTail} = {q, tl};
		cyc(2);
		`CHK(ptrRdData, v);
	endtask

	// ********************
	// Scenarios
	// ********************
	task automatic t_init();
		pci(1'b0, 32'h40, 32'h0);
		`CHK({a, t}, 2'b01);
		{initDone, queueEnable, decodeEnable} = 3'b111;
		pci(1'b0, 32'h40, 32'h0);
		`CHK({a, r, l}, {1'b1, 32'hFFFF_FFFF, 32'd1});
		pci(1'b0, 32'h44, 32'h0);
		`CHK({a, r}, {1'b1, 32'hFFFF_FFFF});
	endtask

	task automatic t_inpost();
		memSlow = 1'b1;
		pci(1'b1, 32'h40, 32'h0000_1200);
		`CHK(a, 1'b1);
		pci(1'b0, 32'h44, 32'h0);
		`CHK(t, 1'b1);
		cyc(10);
		`CHK(u_mem.mem[qa(1, 0)], 32'h0000_1200);
		`CHK({inPostNotEmpty, local_irq_out_n}, 2'b10);
		ptrchk(QIN_POST, 1'b0, 19'h4);
		inPostIrqMask = 1'b1;
		#1 `CHK(local_irq_out_n, 1'b1);
		inPostIrqMask = 1'b0;
		ptrw(QIN_POST, 1'b1, 19'h4);
		#1 `CHK({inPostNotEmpty, local_irq_out_n}, 2'b01);
	endtask

	task automatic t_infree();
		u_mem.mem[qa(0, 0)] = 32'h0000_2000;
		u_mem.mem[qa(0, 4)] = 32'h0000_3000;
		inFreePrefetchEn = 1'b1;
		ptrw(QIN_FREE, 1'b0, 19'h8);
		cyc(12);
		pci(1'b0, 32'h40, 32'h0);
		`CHK({r, l}, {32'h0000_2000, 32'd1});
		cyc(12);
		pci(1'b0, 32'h40, 32'h0);
		`CHK({r, l}, {32'h0000_3000, 32'd1});
		pci(1'b0, 32'h40, 32'h0);
		`CHK(r, 32'hFFFF_FFFF);
		ptrchk(QIN_FREE, 1'b1, 19'h8);
	endtask

	task automatic t_outpost();
		u_mem.mem[qa(2, 0)] = 32'h0000_4000;
		ptrw(QOUT_POST, 1'b0, 19'h4);
		cyc(12);
		`CHK({outPostIrqStatus, pciIrq_n}, 2'b10);
		outPostIrqMask = 1'b1;
		#1 `CHK(pciIrq_n, 1'b1);
		outPostIrqMask = 1'b0;
		pci(1'b0, 32'h44, 32'h0);
		`CHK({r, l}, {32'h0000_4000, 32'd1});
		cyc(1);
		`CHK({outPostIrqStatus, pciIrq_n}, 2'b01);
	endtask

	task automatic t_outfree();
		ptrw(QOUT_FREE, 1'b1, 19'h8);
		pci(1'b1, 32'h44, 32'h0000_5000);
		pci(1'b0, 32'h40, 32'h0);
		`CHK(t, 1'b1);
		cyc(10);
		`CHK({fullFlags[3], u_mem.mem[qa(3, 0)]}, {1'b0, 32'h0000_5000});
		pci(1'b1, 32'h44, 32'h0000_6000);
		cyc(10);
		`CHK({fullFlags[3], outFreeOverflow, local_error_irq_n}, 3'b110);
		ovfClear = 1'b1;
		cyc(1);
		ovfClear = 1'b0;
		cyc(1);
		`CHK(outFreeOverflow, 1'b0);
	endtask

	task automatic t_decode();
		pciOffset = 32'h10;
		pciReq = 1'b1;
		#1 `CHK({cfgHit, space1Hit}, 2'b10);
		pciOffset = 32'h100;
		#1 `CHK({space1Hit, space1Addr}, {1'b1, 32'h0800_0100});
		pciReq = 1'b0;
		queueEnable = 1'b0;
		cyc(2);
		`CHK({emptyFlags, fullFlags}, 8'hF0);
	endtask

	// ********************
	// Main sequence
	// ********************
	initial begin
		cyc(6);
		arst_n = 1'b1;
		t_init();
		t_inpost();
		t_infree();
		t_outpost();
		t_outfree();
		t_decode();
		end_of_test();
	end
endmodule

`default_nettype wire
